/* tmr_defines.svh */
// Register indices, reset values and timing counts for the dual timer/counter.
// Assumes a 32-bit AHB-Lite slave where a register's byte address is four times its index.
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// Register indices; byte address = index * 4
`define IDX_CTRL        8'h88
`define IDX_MODE        8'h89
`define IDX_A_LOW       8'h8a
`define IDX_B_LOW       8'h8b
`define IDX_A_HIGH      8'h8c
`define IDX_B_HIGH      8'h8d

// Reset values
`define CTRL_RESET      8'h00
`define MODE_RESET      8'h00
`define COUNT_RESET     8'h00

// Oscillator periods (hclk cycles) per peripheral cycle
`define OSC_PER_PCYCLE  12
`define PCYC_CNT_W      4

`endif

/* tmr_pkg.sv */
// Types shared by the dual timer/counter.
// Bit layouts follow the control and mode registers, high bit first.
package tmr_pkg;

    typedef enum logic [1:0] {
        MODE_PRESCALE13,
        MODE_CASCADE16,
        MODE_RELOAD8,
        MODE_SPLIT
    } tmr_mode_t;

    // One nibble of the mode register
    typedef struct packed {
        logic      pin_gating;
        logic      source_select;
        tmr_mode_t mode;
    } tmr_cfg_t;

    typedef struct packed {
        logic overflow_b;
        logic run_b;
        logic overflow_a;
        logic run_a;
        logic ext_irq_b_flag;
        logic ext_irq_b_type;
        logic ext_irq_a_flag;
        logic ext_irq_a_type;
    } tmr_ctrl_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } tmr_count_t;

    typedef struct packed {
        tmr_count_t count;
        logic       ovf;
    } tmr_step_t;

endpackage

/* pin_sampler.sv */
// Synchronises one port pin and samples it once per peripheral cycle.
// Assumes sample_en is a one-cycle pulse on hclk.
`timescale 1ns/1ps
module pin_sampler (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin_raw,
    input  wire logic sample_en,
    output logic      level_q,
    output logic      fall_q
);
    logic sync1_q;
    logic sync2_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    // High in one sample, low in the next
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_q <= 1'b1;
            fall_q  <= 1'b0;
        end else begin
            fall_q <= sample_en & level_q & ~sync2_q;
            if (sample_en) begin
                level_q <= sync2_q;
            end
        end
    end

endmodule

/* dual_timer_counter.sv */
// Two 16-bit timer/counters with control, mode and count registers on AHB-Lite.
// Assumes pins are asynchronous, acks come from an interrupt controller on hclk.
//
// Contract
// - Timer ticks once per twelve clocks
// - Counter counts high-then-low pin samples
// - Pin edge recognition spans two peripheral cycles
// - Run bit enables counting, keeps count
// - Gate bit adds interrupt pin control
// - Rollover sets overflow flag, raises request
// - Servicing the request clears overflow flag
// - Mode 0: five-bit prescaler feeds high
// - Mode 0: low upper bits ignored
// - Mode 1: sixteen-bit cascade, high sets flag
// - Mode 2: low reloads from high
// - Mode 3: low is timer A
// - Mode 3: high uses timer B bits
// - Source select: clock or pin edges
// - Interrupt pin sets flag, edge or level
// - Count registers readable and writable
// - Timer A: low mode nibble, bits 0,1,4,5
// - Timer B: high mode nibble, bits 2,3,6,7
// - Timer B mode 3 halts; else same
// - Ack clears interrupt flag only edge-triggered
`timescale 1ns/1ps
`include "tmr_defines.svh"
module dual_timer_counter
    import tmr_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        count_pin_a,
    input  wire logic        count_pin_b,
    input  wire logic        ext_irq_a_pin_n,
    input  wire logic        ext_irq_b_pin_n,
    input  wire logic        overflow_a_ack,
    input  wire logic        overflow_b_ack,
    input  wire logic        ext_irq_a_ack,
    input  wire logic        ext_irq_b_ack,
    output logic             overflow_a_irq,
    output logic             overflow_b_irq,
    output logic             ext_irq_a_irq,
    output logic             ext_irq_b_irq
);

    tmr_ctrl_t              ctrl_q;
    tmr_ctrl_t              ctrl_d;
    logic       [7:0]       mode_q;
    logic       [7:0]       mode_d;
    tmr_count_t             cnt_a_q;
    tmr_count_t             cnt_a_d;
    tmr_count_t             cnt_b_q;
    tmr_count_t             cnt_b_d;
    tmr_cfg_t               cfg_a;
    tmr_cfg_t               cfg_b;
    logic [`PCYC_CNT_W-1:0] pcyc_cnt_q;
    logic                   pcyc_en_q;
    logic       [3:0]       pin_raw;
    logic       [3:0]       pin_level;
    logic       [3:0]       pin_fall;
    logic                   wr_pend_q;
    logic       [7:0]       wr_idx_q;
    logic                   addr_ok;
    logic                   rd_take;
    logic                   wr_take;

    // Pin order: count a, count b, interrupt a, interrupt b
    assign pin_raw = {ext_irq_b_pin_n, ext_irq_a_pin_n, count_pin_b, count_pin_a};

    assign cfg_a = tmr_cfg_t'(mode_q[3:0]);
    assign cfg_b = tmr_cfg_t'(mode_q[7:4]);

    // Byte address decode shared by read and write paths
    function automatic logic reg_mapped(input logic [31:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        reg_mapped = (addr[31:10] == 22'h000000) && (addr[1:0] == 2'h0) &&
                     (idx >= `IDX_CTRL) && (idx <= `IDX_B_HIGH);
    endfunction

    // One count step of a timer for modes 0 to 3 (mode 3: low byte only)
    function automatic tmr_step_t advance(input tmr_mode_t mode, input tmr_count_t c);
        logic [5:0]  pre;
        logic [8:0]  w8;
        logic [16:0] w16;
        tmr_step_t   r;
        r.count = c;
        r.ovf   = 1'b0;
        pre     = {1'b0, c.low[4:0]} + 6'h01;
        w8      = {1'b0, c.low} + 9'h001;
        w16     = {1'b0, c} + 17'h00001;
        case (mode)
            MODE_PRESCALE13: begin
                // Upper three low bits untouched and meaningless
                r.count.low[4:0] = pre[4:0];
                if (pre[5]) begin
                    w8           = {1'b0, c.high} + 9'h001;
                    r.count.high = w8[7:0];
                    r.ovf        = w8[8];
                end
            end
            MODE_CASCADE16: begin
                r.count = w16[15:0];
                r.ovf   = w16[16];
            end
            MODE_RELOAD8: begin
                if (w8[8]) begin
                    r.count.low = c.high;
                    r.ovf       = 1'b1;
                end else begin
                    r.count.low = w8[7:0];
                end
            end
            MODE_SPLIT: begin
                r.count.low = w8[7:0];
                r.ovf       = w8[8];
            end
            default: begin
                r.count = c;
            end
        endcase
        return r;
    endfunction

    // Peripheral cycle: one enable pulse every twelve hclk cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pcyc_cnt_q <= '0;
            pcyc_en_q  <= 1'b0;
        end else begin
            pcyc_en_q <= (pcyc_cnt_q == `PCYC_CNT_W'(`OSC_PER_PCYCLE - 1));
            if (pcyc_cnt_q == `PCYC_CNT_W'(`OSC_PER_PCYCLE - 1)) begin
                pcyc_cnt_q <= '0;
            end else begin
                pcyc_cnt_q <= pcyc_cnt_q + `PCYC_CNT_W'(1);
            end
        end
    end

    // Pins sampled once per peripheral cycle; an edge needs two samples
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pin
            pin_sampler u_sampler (
                .hclk      (hclk),
                .hresetn   (hresetn),
                .pin_raw   (pin_raw[gi]),
                .sample_en (pcyc_en_q),
                .level_q   (pin_level[gi]),
                .fall_q    (pin_fall[gi])
            );
        end
    endgenerate

    // Count enables and ticks
    logic      gate_open_a;
    logic      gate_open_b;
    logic      run_en_a;
    logic      run_en_b;
    logic      tick_a;
    logic      tick_b;
    logic      tick_a_high;
    logic      split_a;
    tmr_step_t step_a;
    tmr_step_t step_b;
    logic      ovf_a_set;
    logic      ovf_b_set;

    assign split_a     = (cfg_a.mode == MODE_SPLIT);
    assign gate_open_a = ~cfg_a.pin_gating | pin_level[2];
    assign gate_open_b = ~cfg_b.pin_gating | pin_level[3];
    assign run_en_a    = ctrl_q.run_a & gate_open_a;
    // Timer B loses its run bit to split mode and is then stopped only by its gate or mode 3
    assign run_en_b    = (split_a ? 1'b1 : ctrl_q.run_b) & gate_open_b &
                         (cfg_b.mode != MODE_SPLIT);
    assign tick_a      = run_en_a & (cfg_a.source_select ? pin_fall[0] : pcyc_en_q);
    assign tick_b      = run_en_b & (cfg_b.source_select ? pin_fall[1] : pcyc_en_q);
    assign tick_a_high = split_a & ctrl_q.run_b & pcyc_en_q;
    assign step_a      = advance(cfg_a.mode, cnt_a_q);
    assign step_b      = advance(cfg_b.mode, cnt_b_q);
    assign ovf_a_set   = tick_a & step_a.ovf;
    // In split mode the high byte of timer A owns timer B's flag
    assign ovf_b_set   = split_a ? (tick_a_high & (cnt_a_q.high == 8'hff))
                                 : (tick_b & step_b.ovf);

    // Bus address phase
    assign addr_ok = hsel & hready & htrans[1];
    assign rd_take = addr_ok & ~hwrite;
    assign wr_take = addr_ok & hwrite;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h00;
        end else begin
            wr_pend_q <= wr_take & reg_mapped(haddr);
            wr_idx_q  <= haddr[9:2];
        end
    end

    // Mode register
    always_comb begin
        mode_d = mode_q;
        if (wr_pend_q && wr_idx_q == `IDX_MODE) begin
            mode_d = hwdata[7:0];
        end
    end

    // Control flags; hardware sets win over writes and acks
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_pend_q && wr_idx_q == `IDX_CTRL) begin
            ctrl_d = tmr_ctrl_t'(hwdata[7:0]);
        end
        if (overflow_a_ack) begin
            ctrl_d.overflow_a = 1'b0;
        end
        if (overflow_b_ack) begin
            ctrl_d.overflow_b = 1'b0;
        end
        if (ext_irq_a_ack && ctrl_q.ext_irq_a_type) begin
            ctrl_d.ext_irq_a_flag = 1'b0;
        end
        if (ext_irq_b_ack && ctrl_q.ext_irq_b_type) begin
            ctrl_d.ext_irq_b_flag = 1'b0;
        end
        if (ovf_a_set) begin
            ctrl_d.overflow_a = 1'b1;
        end
        if (ovf_b_set) begin
            ctrl_d.overflow_b = 1'b1;
        end
        // Level mode tracks the pin; edge mode latches the falling edge
        if (ctrl_q.ext_irq_a_type) begin
            if (pin_fall[2]) begin
                ctrl_d.ext_irq_a_flag = 1'b1;
            end
        end else begin
            ctrl_d.ext_irq_a_flag = ~pin_level[2];
        end
        if (ctrl_q.ext_irq_b_type) begin
            if (pin_fall[3]) begin
                ctrl_d.ext_irq_b_flag = 1'b1;
            end
        end else begin
            ctrl_d.ext_irq_b_flag = ~pin_level[3];
        end
    end

    // Counts; a software load in the same cycle beats the increment
    always_comb begin
        cnt_a_d = cnt_a_q;
        cnt_b_d = cnt_b_q;
        if (tick_a) begin
            cnt_a_d.low = step_a.count.low;
            if (!split_a) begin
                cnt_a_d.high = step_a.count.high;
            end
        end
        if (tick_a_high) begin
            cnt_a_d.high = cnt_a_q.high + 8'h01;
        end
        if (tick_b) begin
            cnt_b_d = step_b.count;
        end
        if (wr_pend_q) begin
            case (wr_idx_q)
                `IDX_A_LOW:  cnt_a_d.low  = hwdata[7:0];
                `IDX_A_HIGH: cnt_a_d.high = hwdata[7:0];
                `IDX_B_LOW:  cnt_b_d.low  = hwdata[7:0];
                `IDX_B_HIGH: cnt_b_d.high = hwdata[7:0];
                default:     cnt_a_d      = cnt_a_d;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= tmr_ctrl_t'(`CTRL_RESET);
            mode_q <= `MODE_RESET;
        end else begin
            ctrl_q <= ctrl_d;
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_a_q <= {`COUNT_RESET, `COUNT_RESET};
            cnt_b_q <= {`COUNT_RESET, `COUNT_RESET};
        end else begin
            cnt_a_q <= cnt_a_d;
            cnt_b_q <= cnt_b_d;
        end
    end

    // Read data taken from next-state values so a read right after a write sees it
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (reg_mapped(haddr)) begin
            case (haddr[9:2])
                `IDX_CTRL:   rd_byte = ctrl_d;
                `IDX_MODE:   rd_byte = mode_d;
                `IDX_A_LOW:  rd_byte = cnt_a_d.low;
                `IDX_B_LOW:  rd_byte = cnt_b_d.low;
                `IDX_A_HIGH: rd_byte = cnt_a_d.high;
                `IDX_B_HIGH: rd_byte = cnt_b_d.high;
                default:     rd_byte = 8'h00;
            endcase
        end
    end

    // Zero-wait slave, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (rd_take) begin
                hrdata <= {24'h000000, rd_byte};
            end
        end
    end

    // Requests straight from the flag flip-flops
    always_comb begin
        overflow_a_irq = ctrl_q.overflow_a;
        overflow_b_irq = ctrl_q.overflow_b;
        ext_irq_a_irq  = ctrl_q.ext_irq_a_flag;
        ext_irq_b_irq  = ctrl_q.ext_irq_b_flag;
    end

endmodule

/* dual_timer_counter_sva.sv */
// Checker for the dual timer/counter bus answers and flag outputs.
// Assumes it is bound to dual_timer_counter and sees only its ports.
`timescale 1ns/1ps
module dual_timer_counter_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        ext_irq_a_pin_n,
    input wire logic        ext_irq_b_pin_n,
    input wire logic        overflow_a_ack,
    input wire logic        overflow_b_ack,
    input wire logic        overflow_a_irq,
    input wire logic        overflow_b_irq,
    input wire logic        ext_irq_a_irq,
    input wire logic        ext_irq_b_irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       rd_take;
    logic       mapped;
    logic [5:0] since_a_q;
    logic [5:0] since_b_q;
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    assign mapped  = haddr >= 32'h0000_0220 && haddr <= 32'h0000_0234;
    // Cycles since each interrupt pin was last low, saturating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) since_a_q <= 6'h3f;
        else if (!ext_irq_a_pin_n) since_a_q <= 6'h00;
        else if (since_a_q != 6'h3f) since_a_q <= since_a_q + 6'h01;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) since_b_q <= 6'h3f;
        else if (!ext_irq_b_pin_n) since_b_q <= 6'h00;
        else if (since_b_q != 6'h3f) since_b_q <= since_b_q + 6'h01;
    end
    AST_READY_HIGH: assert property (hreadyout)
        else $error("hreadyout low");
    AST_RESP_OKAY: assert property (!hresp)
        else $error("hresp not okay");
    AST_UPPER_ZERO: assert property (hrdata[31:8] == 24'h0)
        else $error("hrdata upper bits set");
    AST_UNMAPPED_ZERO: assert property (rd_take && !mapped |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_RDATA_HOLD: assert property (!rd_take |=> $stable(hrdata))
        else $error("hrdata moved without a read");
    AST_OVF_A_ACK: assert property (overflow_a_ack |=> !overflow_a_irq)
        else $error("overflow a not cleared by ack");
    AST_OVF_B_ACK: assert property (overflow_b_ack |=> !overflow_b_irq)
        else $error("overflow b not cleared by ack");
    AST_EXT_A_CAUSE: assert property ($rose(ext_irq_a_irq) |-> since_a_q < 6'h28)
        else $error("ext a flag without pin low");
    AST_EXT_B_CAUSE: assert property ($rose(ext_irq_b_irq) |-> since_b_q < 6'h28)
        else $error("ext b flag without pin low");
    COV_OVF_ACK: cover property (overflow_a_irq && overflow_a_ack);
    COV_EXT_EDGE: cover property ($rose(ext_irq_b_irq));
    COV_UNMAPPED: cover property (rd_take && !mapped);
endmodule

bind dual_timer_counter dual_timer_counter_chk dual_timer_counter_chk_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_irq_a_pin_n(ext_irq_a_pin_n), .ext_irq_b_pin_n(ext_irq_b_pin_n),
    .overflow_a_ack(overflow_a_ack), .overflow_b_ack(overflow_b_ack),
    .overflow_a_irq(overflow_a_irq), .overflow_b_irq(overflow_b_irq),
    .ext_irq_a_irq(ext_irq_a_irq), .ext_irq_b_irq(ext_irq_b_irq)
);

/* pin_model.sv */
// Sources of count events and gate levels on the port pins.
// Assumes the bench calls its tasks; pins idle high as with port pull-ups.
`timescale 1ns/1ps
module pin_model (
    input  wire logic hclk,
    output logic      count_pin_a,
    output logic      count_pin_b,
    output logic      ext_irq_a_pin_n,
    output logic      ext_irq_b_pin_n
);
    initial begin
        count_pin_a     = 1'b1;
        count_pin_b     = 1'b1;
        ext_irq_a_pin_n = 1'b1;
        ext_irq_b_pin_n = 1'b1;
    end
    // Levels last 24 clocks so each is sampled despite the synchroniser lag
    task automatic count_pulses(input logic sel_b, input int n);
        repeat (n) begin
            @(posedge hclk);
            if (sel_b) count_pin_b <= 1'b0; else count_pin_a <= 1'b0;
            repeat (24) @(posedge hclk);
            if (sel_b) count_pin_b <= 1'b1; else count_pin_a <= 1'b1;
            repeat (23) @(posedge hclk);
        end
    endtask
    task automatic set_irq_pin(input logic sel_b, input logic lvl);
        @(posedge hclk);
        if (sel_b) ext_irq_b_pin_n <= lvl; else ext_irq_a_pin_n <= lvl;
    endtask
endmodule

/* tb_top.sv */
// Self-checking bench for the dual timer/counter over AHB-Lite.
// Assumes the checker is bound in and pin_model drives the port pins.
`timescale 1ns/1ps
`include "tmr_defines.svh"
module tb_top
    import tmr_pkg::*;
;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        cpa, cpb, ipa, ipb;
    logic [1:0]  ovf_ack, ovf_irq, ext_ack, ext_irq;
    logic [31:0] rd, v;
    logic [7:0]  mdl [0:6];
    int          error_cnt, n_checks, i, t, n [0:1];
    integer      seed;

    dual_timer_counter dual_timer_counter_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .count_pin_a(cpa), .count_pin_b(cpb), .ext_irq_a_pin_n(ipa), .ext_irq_b_pin_n(ipb),
        .overflow_a_ack(ovf_ack[0]), .overflow_b_ack(ovf_ack[1]),
        .ext_irq_a_ack(ext_ack[0]), .ext_irq_b_ack(ext_ack[1]),
        .overflow_a_irq(ovf_irq[0]), .overflow_b_irq(ovf_irq[1]),
        .ext_irq_a_irq(ext_irq[0]), .ext_irq_b_irq(ext_irq[1])
    );
    pin_model pin_model_inst (
        .hclk(hclk), .count_pin_a(cpa), .count_pin_b(cpb),
        .ext_irq_a_pin_n(ipa), .ext_irq_b_pin_n(ipb)
    );

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic in_rng(input string name, input logic [31:0] s, input int lo, input int hi);
        check(name, {31'h0, (s >= lo && s <= hi)}, 32'h1);
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge hclk);
    endtask
    task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
        if (idx != 8'h8e) mdl[idx - 8'h88] = d;
    endtask
    task automatic rd_chk(input logic [7:0] idx);
        bus(idx, 1'b0, 8'h00);
        check($sformatf("reg %h", idx), rd, {24'h0, mdl[idx - 8'h88]});
    endtask
    // Waits for an overflow request, then services it
    task automatic ovf_service(input int k);
        for (i = 0; i < 400 && ovf_irq[k] !== 1'b1; i++) @(posedge hclk);
        #1 check("overflow request", {31'h0, ovf_irq[k]}, 32'h1);
        @(posedge hclk);
        ovf_ack[k] <= 1'b1;
        @(posedge hclk);
        ovf_ack[k] <= 1'b0;
        #1 check("overflow after ack", {31'h0, ovf_irq[k]}, 32'h0);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #(50 * 60000);
        error_cnt++;
        final_report();
    end

    initial begin
        seed = 32'h8e38;
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
        {ovf_ack, ext_ack} = 4'h0;
        for (i = 0; i < 7; i++) mdl[i] = 8'h00;
        hresetn = 1'b0;
        cyc(12);
        hresetn <= 1'b1;
        for (i = 0; i < 7; i++) rd_chk(8'h88 + i);
        for (i = 1; i < 7; i++) wr(8'h88 + i, 8'($random(seed)) & (i == 1 ? 8'hfd : 8'hff));
        for (i = 1; i < 7; i++) rd_chk(8'h88 + i);
        wr(`IDX_MODE, 8'h01);
        wr(`IDX_A_LOW, 8'h00);
        wr(`IDX_CTRL, 8'h10);
        cyc(480);
        wr(`IDX_CTRL, 8'h00);
        bus(`IDX_A_LOW, 1'b0, 8'h00);
        in_rng("tick rate", rd, 39, 42);
        v = rd;
        wr(`IDX_CTRL, 8'h10);
        cyc(240);
        wr(`IDX_CTRL, 8'h00);
        bus(`IDX_A_LOW, 1'b0, 8'h00);
        in_rng("resumed count", rd - v, 19, 22);
        wr(`IDX_A_LOW, 8'hfd);
        wr(`IDX_A_HIGH, 8'hff);
        wr(`IDX_CTRL, 8'h10);
        for (i = 0; i < 400 && ovf_irq[0] !== 1'b1; i++) @(posedge hclk);
        bus(`IDX_CTRL, 1'b0, 8'h00);
        check("overflow a flag", {31'h0, rd[5]}, 32'h1);
        ovf_service(0);
        wr(`IDX_CTRL, 8'h00);
        bus(`IDX_A_HIGH, 1'b0, 8'h00);
        check("cascade high", rd, 32'h0);
        // Both timers in reload mode, rolling over on the same tick
        wr(`IDX_MODE, 8'h22);
        wr(`IDX_B_HIGH, 8'hf0);
        wr(`IDX_B_LOW, 8'hfe);
        wr(`IDX_A_HIGH, 8'he0);
        wr(`IDX_A_LOW, 8'hfe);
        wr(`IDX_CTRL, 8'h50);
        ovf_service(1);
        ovf_service(0);
        wr(`IDX_CTRL, 8'h00);
        rd_chk(`IDX_B_HIGH);
        rd_chk(`IDX_A_HIGH);
        bus(`IDX_B_LOW, 1'b0, 8'h00);
        in_rng("reloaded low", rd, 240, 242);
        bus(`IDX_A_LOW, 1'b0, 8'h00);
        in_rng("reloaded low a", rd, 224, 226);
        wr(`IDX_MODE, 8'h00);
        wr(`IDX_A_LOW, 8'hff);
        wr(`IDX_A_HIGH, 8'h10);
        wr(`IDX_CTRL, 8'h10);
        cyc(30);
        wr(`IDX_CTRL, 8'h00);
        bus(`IDX_A_HIGH, 1'b0, 8'h00);
        check("prescaled high", rd, 32'h11);
        bus(`IDX_A_LOW, 1'b0, 8'h00);
        in_rng("prescaler", rd & 32'h1f, 1, 2);
        // Pin counting on both timers, clock source deselected
        wr(`IDX_MODE, 8'h55);
        for (i = 0; i < 4; i++) wr(8'h8a + i, 8'h00);
        wr(`IDX_CTRL, 8'h50);
        for (t = 0; t < 2; t++) begin
            n[t] = 1 + ($random(seed) & 7);
            pin_model_inst.count_pulses(t[0], n[t]);
        end
        cyc(40);
        wr(`IDX_CTRL, 8'h00);
        for (t = 0; t < 2; t++) begin
            bus(8'h8a + t, 1'b0, 8'h00);
            check("pin count", rd, n[t]);
        end
        // Gated timers with level-mode flags
        wr(`IDX_MODE, 8'h99);
        for (t = 0; t < 2; t++) pin_model_inst.set_irq_pin(t[0], 1'b0);
        cyc(30);
        for (i = 0; i < 4; i++) wr(8'h8a + i, 8'h00);
        wr(`IDX_CTRL, 8'h50);
        cyc(240);
        @(posedge hclk);
        ext_ack <= 2'b11;
        @(posedge hclk);
        ext_ack <= 2'b00;
        cyc(2);
        #1 check("level flags", ext_irq, 2'b11);
        for (t = 0; t < 2; t++) begin
            bus(8'h8a + t, 1'b0, 8'h00);
            check("gate closed", rd, 32'h0);
            pin_model_inst.set_irq_pin(t[0], 1'b1);
        end
        cyc(240);
        wr(`IDX_CTRL, 8'h00);
        #1 check("level flags idle", ext_irq, 2'b00);
        for (t = 0; t < 2; t++) begin
            bus(8'h8a + t, 1'b0, 8'h00);
            in_rng("gate open", rd, 16, 21);
        end
        wr(`IDX_CTRL, 8'h05);
        for (t = 0; t < 2; t++) pin_model_inst.set_irq_pin(t[0], 1'b0);
        cyc(24);
        for (t = 0; t < 2; t++) pin_model_inst.set_irq_pin(t[0], 1'b1);
        cyc(30);
        #1 check("edge flags", ext_irq, 2'b11);
        @(posedge hclk);
        ext_ack <= 2'b11;
        @(posedge hclk);
        ext_ack <= 2'b00;
        cyc(2);
        #1 check("edge flags acked", ext_irq, 2'b00);
        rd_chk(`IDX_CTRL);
        // Split timer A, halted timer B
        wr(`IDX_MODE, 8'h33);
        wr(`IDX_A_LOW, 8'h07);
        wr(`IDX_A_HIGH, 8'hfe);
        wr(`IDX_B_LOW, 8'h05);
        wr(`IDX_CTRL, 8'h40);
        ovf_service(1);
        wr(`IDX_CTRL, 8'h00);
        rd_chk(`IDX_A_LOW);
        rd_chk(`IDX_B_LOW);
        bus(`IDX_A_HIGH, 1'b0, 8'h00);
        in_rng("split high", rd, 0, 2);
        final_report();
    end
endmodule
